// [shared/eddf_pkg.sv]
// Constants and types for the descriptor field engine
package eddf_pkg;
	localparam int ADR_W = 8;
	localparam int FL_W  = 14;
	localparam int SZ_W  = 13;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [ADR_W-1:0] OFS_TX_BUF1 = 8'h00;
	localparam logic [ADR_W-1:0] OFS_TX_NEXT = 8'h04;
	localparam logic [ADR_W-1:0] OFS_TX_CTRL = 8'h08;
	localparam logic [ADR_W-1:0] OFS_TX_STLO = 8'h0c;
	localparam logic [ADR_W-1:0] OFS_TX_STHI = 8'h10;
	localparam logic [ADR_W-1:0] OFS_TX_STAT = 8'h14;
	localparam logic [ADR_W-1:0] OFS_RX_STAT = 8'h18;
	localparam logic [ADR_W-1:0] OFS_RX_CTRL = 8'h1c;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int TXC_SZ_MSB = 12;
	localparam int TXC_LAST   = 13;
	localparam int TXC_GO     = 14;
	localparam int TXS_VALID  = 0;
	localparam int TXS_BUSY   = 1;
	localparam int RXC_CAP_MSB = 13;
	localparam int RXC_CSUM   = 16;
	localparam int RXC_NXOWN  = 17;
	localparam int RS_OWN   = 31;
	localparam int RS_DAF   = 30;
	localparam int RS_FL_MSB = 29;
	localparam int RS_FL_LSB = 16;
	localparam int RS_ES    = 15;
	localparam int RS_NNB   = 14;
	localparam int RS_SAF   = 13;
	localparam int RS_LEN   = 12;
	localparam int RS_OVF   = 11;
	localparam int RS_VLAN  = 10;
	localparam int RS_FIRST = 9;
	localparam int RS_LAST  = 8;
	localparam int RS_GIANT = 7;
	localparam int RS_LCOL  = 6;
	localparam int RS_FTYPE = 5;
	localparam int RS_WDOG  = 4;
	localparam int RS_RXERR = 3;
	localparam int RS_CRC   = 1;

	localparam logic [31:0]     ZERO_W     = 32'h0000_0000;
	localparam logic [FL_W-1:0] CSUM_EXTRA = 14'h0002;
	localparam logic [FL_W-1:0] ONE_BYTE   = 14'h0001;

	typedef struct packed {
		logic crc;
		logic rx_err;
		logic wdog;
		logic late_col;
		logic giant;
		logic ip_err;
		logic overflow;
		logic da_fail;
		logic sa_fail;
		logic len_bad;
		logic eth_type;
		logic vlan;
		logic ctrl_frame;
	} eddf_rx_info_t;

	typedef struct packed {
		logic [31:0] hi;
		logic [31:0] lo;
	} eddf_stamp_t;

	typedef enum logic [2:0] {
		RX_IDLE = 3'h1,
		RX_FILL = 3'h2,
		RX_DROP = 3'h4
	} eddf_rx_state_t;
endpackage

// [sim/eddf_core_tb_top.sv]
// Self-checking bench for the descriptor field engine
`timescale 1ns/1ns
module eddf_core_tb_top;
	logic        clk, rstn, cyc, stb, we, ack, f_data, f_desc, done, ok, tok;
	logic        sof, rbyte, eof, vld, own;
	logic [7:0]  adr, dly;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat, rbus, faddr, wword, daddr;
	eddf_pkg::eddf_stamp_t   stamp, tstamp;
	eddf_pkg::eddf_rx_info_t info;
	logic [31:0] wq[$];
	int          fail_count, samples_checked, cycles, ndesc;

	eddf_core dut (.i_clk(clk), .i_rstn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rbus), .o_wb_ack(ack),
		.o_fetch_addr(faddr), .o_fetch_data(f_data), .o_fetch_desc(f_desc), .i_tx_done(done),
		.i_tx_stamp(tstamp), .i_tx_stamp_ok(tok), .i_rx_sof(sof), .i_rx_byte(rbyte),
		.i_rx_eof(eof), .i_rx_info(info), .o_rx_wbk_word(wword), .o_rx_wbk_vld(vld),
		.o_rx_own(own));
	eddf_mem_model mem (.i_clk(clk), .i_rstn(rstn), .i_fetch_data(f_data),
		.i_fetch_desc(f_desc), .i_dly(dly), .i_stamp(stamp), .i_ok(ok), .o_tx_done(done),
		.o_tx_stamp(tstamp), .o_tx_stamp_ok(tok));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// ------
	// Monitors and timeout
	// ------
	always @(posedge clk) begin
		cycles++;
		if (vld === 1'b1) wq.push_back(wword);
		if (f_desc === 1'b1) begin
			ndesc++;
			daddr = faddr;
		end
		if (cycles == 20000) begin
			fail_count++;
			complete_run;
		end
	end
	task complete_run;
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
		samples_checked++;
		if ((got & m) !== (exp & m)) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// ------
	// Bus and stream drivers
	// ------
	// Holds the request until ack is sampled, then idles one cycle
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		rdat = rbus;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0, 4'hf);
		chk(rdat, exp, '1);
	endtask
	task rx_frame(input eddf_pkg::eddf_rx_info_t inf, input int n);
		@(posedge clk);
		sof <= 1'b1;
		@(posedge clk);
		sof <= 1'b0;
		for (int i = 0; i < n; i++) begin
			rbyte <= 1'b1;
			@(posedge clk);
		end
		rbyte <= 1'b0;
		eof <= 1'b1;
		info <= inf;
		@(posedge clk);
		eof <= 1'b0;
		info <= ~inf;
		repeat (2) @(posedge clk);
	endtask
	// ------
	// Scenarios
	// ------
	task t_regs;
		rd(eddf_pkg::OFS_TX_STAT, 32'h0);
		wb(1'b1, eddf_pkg::OFS_TX_BUF1, 32'h1234_5678, 4'hf);
		wb(1'b1, eddf_pkg::OFS_TX_NEXT, 32'h0, 4'hf);
		wb(1'b1, eddf_pkg::OFS_TX_NEXT, 32'haabb_ccdd, 4'h2);
		rd(eddf_pkg::OFS_TX_BUF1, 32'h1234_5678);
		rd(eddf_pkg::OFS_TX_NEXT, 32'h0000_cc00);
		wb(1'b1, 8'h40, 32'hffff_ffff, 4'hf);
		rd(8'h40, 32'h0);
		wb(1'b1, eddf_pkg::OFS_TX_STLO, 32'hffff_ffff, 4'hf);
		rd(eddf_pkg::OFS_TX_STLO, 32'h0);
	endtask
	// Go, check the fetch in the next cycle, poll until idle, check status
	task t_tx(input logic [31:0] c, input logic xd, input logic [31:0] xa, input logic [31:0] xs);
		wb(1'b1, eddf_pkg::OFS_TX_CTRL, c, 4'hf);
		@(posedge clk);
		chk({30'h0, f_data, f_desc}, {30'h0, xd, ~xd}, '1);
		chk(faddr, xa, '1);
		if (dly > 8'h05) rd(eddf_pkg::OFS_TX_STAT, 32'h2);
		rdat = 32'h2;
		for (int i = 0; i < 50 && rdat[1] !== 1'b0; i++) wb(1'b0, eddf_pkg::OFS_TX_STAT, 32'h0, 4'hf);
		chk(rdat, xs, '1);
	endtask
	task t_rx(input logic [31:0] rc, input eddf_pkg::eddf_rx_info_t inf, input int n,
		input logic [31:0] exp, input logic [31:0] m, input int nw);
		wb(1'b1, eddf_pkg::OFS_RX_CTRL, rc, 4'hf);
		wb(1'b1, eddf_pkg::OFS_RX_STAT, 32'h8000_0000, 4'hf);
		rd(eddf_pkg::OFS_RX_STAT, 32'h8000_0000);
		wq.delete();
		rx_frame(inf, n);
		if (nw != 0) chk(32'(wq.size()), 32'(nw), '1);
		if (wq.size() != 0) chk(wq[0], exp, m);
		chk({31'h0, own}, 32'h0, '1);
	endtask
	task t_errs;
		logic [31:0] xb [7];
		xb = '{32'h800, 32'h0, 32'h80, 32'h40, 32'h10, 32'h8, 32'h2};
		for (int k = 6; k < 13; k++) t_rx(32'h64, 13'h1 << k, 1, 32'h0001_8300 | xb[k-6], '1, 1);
	endtask
	initial begin
		{rstn, cyc, stb, we, ok, sof, rbyte, eof} = '0;
		{adr, sel, wdat, info, fail_count, samples_checked, cycles, ndesc} = '0;
		dly = 8'd20;
		stamp = 64'h0bad_cafe_1357_9bdf;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		t_regs;
		ok <= 1'b1;
		t_tx(32'h6040, 1'b1, 32'h1234_5678, 32'h1);
		rd(eddf_pkg::OFS_TX_STLO, 32'h1357_9bdf);
		rd(eddf_pkg::OFS_TX_STHI, 32'h0bad_cafe);
		ndesc = 0;
		t_tx(32'h4040, 1'b1, 32'h1234_5678, 32'h0);
		chk(32'(ndesc), 32'h1, '1);
		chk(daddr, 32'h0000_cc00, '1);
		dly <= 8'd0;
		ok <= 1'b0;
		t_tx(32'h6000, 1'b0, 32'h0000_cc00, 32'h0);
		rd(eddf_pkg::OFS_TX_STLO, 32'h1357_9bdf);
		t_rx(32'h1_0064, 13'h3a, 5, 32'h4007_3700, '1, 1);
		t_rx(32'h1_0064, 13'h0d, 3, 32'h0003_0320, '1, 1);
		t_errs;
		t_rx(32'h2, 13'h0, 4, 32'h0002_c300, '1, 0);
		t_rx(32'h2_0002, 13'h0, 3, 32'h0000_0200, 32'h8000_4300, 2);
		chk(wq[1], 32'h0000_0100, 32'h8000_0300);
		t_rx(32'h2_0000, 13'h0, 2, 32'h0, 32'h8000_0300, 2);
		chk(wq[1], 32'h0000_0300, 32'h8000_0300);
		wq.delete();
		rx_frame(13'h0, 2);
		chk(32'(wq.size()), 32'h0, '1);
		complete_run;
	end
endmodule

// [sim/eddf_mem_model.sv]
// Host memory model: answers fetches with a transmit completion
`timescale 1ns/1ns
module eddf_mem_model (
	input  wire logic                  i_clk,
	input  wire logic                  i_rstn,
	input  wire logic                  i_fetch_data,
	input  wire logic                  i_fetch_desc,
	input  wire logic [7:0]            i_dly,
	input  wire eddf_pkg::eddf_stamp_t i_stamp,
	input  wire logic                  i_ok,
	output logic                       o_tx_done,
	output eddf_pkg::eddf_stamp_t      o_tx_stamp,
	output logic                       o_tx_stamp_ok
);
	// ------
	// Completion timer
	// ------
	logic [7:0] cnt_ff;
	logic       run_ff;
	// Buffer fetch and chained descriptor fetch both end in done
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_ff <= 8'h00;
			run_ff <= 1'b0;
			o_tx_done <= 1'b0;
		end else begin
			o_tx_done <= 1'b0;
			if (i_fetch_data || i_fetch_desc) begin
				run_ff <= 1'b1;
				cnt_ff <= i_dly;
			end else if (run_ff && cnt_ff != 8'h00) begin
				cnt_ff <= cnt_ff - 8'h01;
			end else if (run_ff) begin
				run_ff <= 1'b0;
				o_tx_done <= 1'b1;
			end
		end
	end
	// Stamp lines carry junk outside the done pulse, no stale hold
	assign o_tx_stamp    = o_tx_done ? i_stamp : ~i_stamp;
	assign o_tx_stamp_ok = o_tx_done ? i_ok : ~i_ok;
endmodule

// [src/eddf_core.sv]
// Descriptor field engine: tx pointer/stamp handling, rx status word
// ----------------------------------------
// ----------------------------------------
//
// The register offsets and the Wishbone register port were left to the implementer.
`timescale 1ns/1ns
module eddf_core (
	input  wire logic                      i_clk,
	input  wire logic                      i_rstn,
	input  wire logic                      i_wb_cyc,
	input  wire logic                      i_wb_stb,
	input  wire logic                      i_wb_we,
	input  wire logic [eddf_pkg::ADR_W-1:0] i_wb_adr,
	input  wire logic [3:0]                i_wb_sel,
	input  wire logic [31:0]               i_wb_dat,
	output logic      [31:0]               o_wb_dat,
	output logic                           o_wb_ack,
	output logic      [31:0]               o_fetch_addr,
	output logic                           o_fetch_data,
	output logic                           o_fetch_desc,
	input  wire logic                      i_tx_done,
	input  wire eddf_pkg::eddf_stamp_t     i_tx_stamp,
	input  wire logic                      i_tx_stamp_ok,
	input  wire logic                      i_rx_sof,
	input  wire logic                      i_rx_byte,
	input  wire logic                      i_rx_eof,
	input  wire eddf_pkg::eddf_rx_info_t   i_rx_info,
	output logic      [31:0]               o_rx_wbk_word,
	output logic                           o_rx_wbk_vld,
	output logic                           o_rx_own
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic err_any(input eddf_pkg::eddf_rx_info_t f,
		input logic nnb);
		return f.crc | f.rx_err | f.wdog | f.late_col | f.giant
			| f.ip_err | f.overflow | nnb;
	endfunction

	// ----------------------------------------
	// Wishbone slave
	// ----------------------------------------
	logic [31:0] tx_buf1_ff, tx_next_ff, tx_ctrl_ff, stlo_ff, sthi_ff;
	logic [31:0] rx_stat_ff, rx_ctrl_ff;
	logic        busy_ff, valid_ff;
	logic        ack_ff;
	logic [31:0] rdat_ff;

	wire req    = i_wb_cyc & i_wb_stb;
	wire wr_en  = req & i_wb_we & ack_ff;
	wire hit_b1 = i_wb_adr == eddf_pkg::OFS_TX_BUF1;
	wire hit_nx = i_wb_adr == eddf_pkg::OFS_TX_NEXT;
	wire hit_tc = i_wb_adr == eddf_pkg::OFS_TX_CTRL;
	wire hit_rs = i_wb_adr == eddf_pkg::OFS_RX_STAT;
	wire hit_rc = i_wb_adr == eddf_pkg::OFS_RX_CTRL;
	wire [31:0] tx_stat_w = {30'h0, busy_ff, valid_ff};

	logic [31:0] rd_mux;
	always_comb begin
		unique case (i_wb_adr)
			eddf_pkg::OFS_TX_BUF1: rd_mux = tx_buf1_ff;
			eddf_pkg::OFS_TX_NEXT: rd_mux = tx_next_ff;
			eddf_pkg::OFS_TX_CTRL: rd_mux = tx_ctrl_ff;
			eddf_pkg::OFS_TX_STLO: rd_mux = stlo_ff;
			eddf_pkg::OFS_TX_STHI: rd_mux = sthi_ff;
			eddf_pkg::OFS_TX_STAT: rd_mux = tx_stat_w;
			eddf_pkg::OFS_RX_STAT: rd_mux = rx_stat_ff;
			eddf_pkg::OFS_RX_CTRL: rd_mux = rx_ctrl_ff;
			default:               rd_mux = eddf_pkg::ZERO_W;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ack_ff  <= 1'b0;
			rdat_ff <= eddf_pkg::ZERO_W;
		end else begin
			ack_ff  <= req & ~ack_ff;
			rdat_ff <= rd_mux;
		end
	end
	assign o_wb_ack = ack_ff;
	assign o_wb_dat = rdat_ff;

	// ----------------------------------------
	// Transmit side
	// ----------------------------------------
	wire [31:0] tc_new = wb_merge(tx_ctrl_ff, i_wb_dat, i_wb_sel);
	wire go        = wr_en & hit_tc & tc_new[eddf_pkg::TXC_GO];
	wire size_zero = tc_new[eddf_pkg::TXC_SZ_MSB:0] == '0;
	wire tx_last   = tx_ctrl_ff[eddf_pkg::TXC_LAST];
	wire tx_end    = i_tx_done & busy_ff;
	wire stamp_ok  = tx_end & tx_last & i_tx_stamp_ok;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			tx_buf1_ff   <= eddf_pkg::ZERO_W;
			tx_next_ff   <= eddf_pkg::ZERO_W;
			tx_ctrl_ff   <= eddf_pkg::ZERO_W;
			rx_ctrl_ff   <= eddf_pkg::ZERO_W;
			stlo_ff      <= eddf_pkg::ZERO_W;
			sthi_ff      <= eddf_pkg::ZERO_W;
			busy_ff      <= 1'b0;
			valid_ff     <= 1'b0;
			o_fetch_addr <= eddf_pkg::ZERO_W;
			o_fetch_data <= 1'b0;
			o_fetch_desc <= 1'b0;
		end else begin
			o_fetch_data <= 1'b0;
			o_fetch_desc <= 1'b0;
			if (wr_en & hit_b1) begin
				tx_buf1_ff <= wb_merge(tx_buf1_ff, i_wb_dat, i_wb_sel);
			end
			if (wr_en & hit_nx) begin
				tx_next_ff <= wb_merge(tx_next_ff, i_wb_dat, i_wb_sel);
			end
			if (wr_en & hit_rc) begin
				rx_ctrl_ff <= wb_merge(rx_ctrl_ff, i_wb_dat, i_wb_sel);
			end
			// Go bit self-clears so a later write that leaves byte 1 unselected never restarts a transfer
			if (wr_en & hit_tc) begin
				tx_ctrl_ff <= tc_new & ~(32'h1 << eddf_pkg::TXC_GO);
			end
			if (go & ~busy_ff) begin
				busy_ff  <= 1'b1;
				valid_ff <= 1'b0;
				if (size_zero) begin
					o_fetch_addr <= tx_next_ff;
					o_fetch_desc <= 1'b1;
				end else begin
					o_fetch_addr <= tx_buf1_ff;
					o_fetch_data <= 1'b1;
				end
			end else if (tx_end) begin
				busy_ff <= 1'b0;
				if (stamp_ok) begin
					stlo_ff  <= i_tx_stamp.lo;
					sthi_ff  <= i_tx_stamp.hi;
					valid_ff <= 1'b1;
				end
				if (!tx_last) begin
					o_fetch_addr <= tx_next_ff;
					o_fetch_desc <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// Receive status word
	// ----------------------------------------
	eddf_pkg::eddf_rx_state_t state_ff, nxt_state;
	logic [eddf_pkg::FL_W-1:0] cnt_ff, nxt_cnt, len_ff, nxt_len;
	logic        first_ff, nxt_first;
	logic [31:0] nxt_stat, nxt_wbk_w, wbk_w_ff;
	logic        nxt_wbk_v, wbk_v_ff;

	wire own      = rx_stat_ff[eddf_pkg::RS_OWN];
	wire [eddf_pkg::FL_W-1:0] cap = rx_ctrl_ff[eddf_pkg::RXC_CAP_MSB:0];
	wire buf_full = cnt_ff == cap;
	wire nx_own   = rx_ctrl_ff[eddf_pkg::RXC_NXOWN];
	wire add_two  = rx_ctrl_ff[eddf_pkg::RXC_CSUM] & ~i_rx_info.ctrl_frame;
	wire [eddf_pkg::FL_W-1:0] fin_len = len_ff + (add_two ? eddf_pkg::CSUM_EXTRA
		: '0);
	// Host writes land only when the engine leaves the word alone
	wire sw_rs    = wr_en & hit_rs;
	wire [31:0] sw_stat = wb_merge(rx_stat_ff, i_wb_dat, i_wb_sel);

	logic [31:0] eof_w, trunc_w, full_w;
	always_comb begin
		eof_w = rx_stat_ff;
		eof_w[eddf_pkg::RS_OWN]   = 1'b0;
		eof_w[eddf_pkg::RS_LAST]  = 1'b1;
		eof_w[eddf_pkg::RS_FL_MSB:eddf_pkg::RS_FL_LSB] = fin_len;
		eof_w[eddf_pkg::RS_DAF]   = i_rx_info.da_fail;
		eof_w[eddf_pkg::RS_SAF]   = i_rx_info.sa_fail;
		eof_w[eddf_pkg::RS_LEN]   = i_rx_info.len_bad & ~i_rx_info.eth_type;
		eof_w[eddf_pkg::RS_OVF]   = i_rx_info.overflow;
		eof_w[eddf_pkg::RS_VLAN]  = i_rx_info.vlan;
		eof_w[eddf_pkg::RS_GIANT] = i_rx_info.giant;
		eof_w[eddf_pkg::RS_LCOL]  = i_rx_info.late_col;
		eof_w[eddf_pkg::RS_FTYPE] = i_rx_info.eth_type;
		eof_w[eddf_pkg::RS_WDOG]  = i_rx_info.wdog;
		eof_w[eddf_pkg::RS_RXERR] = i_rx_info.rx_err;
		eof_w[eddf_pkg::RS_CRC]   = i_rx_info.crc;
		eof_w[eddf_pkg::RS_ES]    = err_any(i_rx_info, 1'b0);
		trunc_w = rx_stat_ff;
		trunc_w[eddf_pkg::RS_OWN]  = 1'b0;
		trunc_w[eddf_pkg::RS_LAST] = 1'b1;
		trunc_w[eddf_pkg::RS_NNB]  = 1'b1;
		trunc_w[eddf_pkg::RS_FL_MSB:eddf_pkg::RS_FL_LSB] = len_ff;
		trunc_w[eddf_pkg::RS_ES]   = err_any(i_rx_info, 1'b1);
		full_w = rx_stat_ff;
		full_w[eddf_pkg::RS_OWN]   = 1'b0;
	end

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_len   = len_ff;
		nxt_first = first_ff;
		nxt_stat  = sw_rs ? sw_stat : rx_stat_ff;
		nxt_wbk_v = 1'b0;
		nxt_wbk_w = wbk_w_ff;
		unique case (state_ff)
			eddf_pkg::RX_IDLE: begin
				if (i_rx_sof) begin
					nxt_cnt   = '0;
					nxt_len   = '0;
					nxt_first = 1'b1;
					nxt_state = own ? eddf_pkg::RX_FILL : eddf_pkg::RX_DROP;
				end
			end
			eddf_pkg::RX_FILL: begin
				if (i_rx_eof) begin
					nxt_stat  = eof_w;
					nxt_wbk_w = eof_w;
					nxt_wbk_v = 1'b1;
					nxt_state = eddf_pkg::RX_IDLE;
				end else if (i_rx_byte & ~own) begin
					nxt_state = eddf_pkg::RX_DROP;
				end else if (i_rx_byte & buf_full & ~nx_own) begin
					nxt_stat  = trunc_w;
					nxt_wbk_w = trunc_w;
					nxt_wbk_v = 1'b1;
					nxt_state = eddf_pkg::RX_DROP;
				end else if (i_rx_byte) begin
					// Full buffer: release it, continue in next descriptor
					if (buf_full) begin
						nxt_wbk_w = full_w;
						nxt_wbk_v = 1'b1;
						nxt_stat  = 32'h1 << eddf_pkg::RS_OWN;
					end
					// Zero capacity never stores, so the start moves on
					nxt_stat[eddf_pkg::RS_FIRST] = nxt_stat[eddf_pkg::RS_FIRST] | first_ff;
					nxt_first = 1'b0;
					nxt_cnt   = (buf_full ? '0 : cnt_ff) + eddf_pkg::ONE_BYTE;
					nxt_len   = len_ff + eddf_pkg::ONE_BYTE;
				end
			end
			eddf_pkg::RX_DROP: begin
				if (i_rx_eof) begin
					nxt_state = eddf_pkg::RX_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_ff   <= eddf_pkg::RX_IDLE;
			cnt_ff     <= '0;
			len_ff     <= '0;
			first_ff   <= 1'b0;
			rx_stat_ff <= eddf_pkg::ZERO_W;
			wbk_w_ff   <= eddf_pkg::ZERO_W;
			wbk_v_ff   <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			cnt_ff     <= nxt_cnt;
			len_ff     <= nxt_len;
			first_ff   <= nxt_first;
			rx_stat_ff <= nxt_stat;
			wbk_w_ff   <= nxt_wbk_w;
			wbk_v_ff   <= nxt_wbk_v;
		end
	end
	assign o_rx_wbk_word = wbk_w_ff;
	assign o_rx_wbk_vld  = wbk_v_ff;
	assign o_rx_own      = rx_stat_ff[eddf_pkg::RS_OWN];

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_ack_single: assert property (@(posedge i_clk) disable iff (!i_rstn)
		req & ~o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
		else $error("ack not a single cycle after request");
	a_zero_skip: assert property (@(posedge i_clk) disable iff (!i_rstn)
		go & ~busy_ff & size_zero |=> o_fetch_desc && !o_fetch_data
			&& o_fetch_addr == $past(tx_next_ff))
		else $error("zero size buffer not skipped");
	a_buf_fetch: assert property (@(posedge i_clk) disable iff (!i_rstn)
		go & ~busy_ff & ~size_zero |=> o_fetch_data
			&& o_fetch_addr == $past(tx_buf1_ff))
		else $error("buffer fetch address wrong");
	a_stamp_low: assert property (@(posedge i_clk) disable iff (!i_rstn)
		stamp_ok |=> stlo_ff == $past(i_tx_stamp.lo) && valid_ff)
		else $error("low stamp not captured");
	a_stamp_high: assert property (@(posedge i_clk) disable iff (!i_rstn)
		stamp_ok |=> sthi_ff == $past(i_tx_stamp.hi))
		else $error("high stamp not captured");
	a_stamp_gate: assert property (@(posedge i_clk) disable iff (!i_rstn)
		$rose(valid_ff) |-> $past(tx_last) && $past(i_tx_stamp_ok))
		else $error("stamp valid without last and flag");
	a_own_release: assert property (@(posedge i_clk) disable iff (!i_rstn)
		o_rx_wbk_vld |-> !o_rx_wbk_word[eddf_pkg::RS_OWN])
		else $error("released word still owned");
	a_err_sum: assert property (@(posedge i_clk) disable iff (!i_rstn)
		o_rx_wbk_vld && o_rx_wbk_word[eddf_pkg::RS_LAST]
			&& (o_rx_wbk_word[eddf_pkg::RS_CRC] | o_rx_wbk_word[eddf_pkg::RS_RXERR]
			| o_rx_wbk_word[eddf_pkg::RS_WDOG] | o_rx_wbk_word[eddf_pkg::RS_LCOL]
			| o_rx_wbk_word[eddf_pkg::RS_GIANT] | o_rx_wbk_word[eddf_pkg::RS_OVF]
			| o_rx_wbk_word[eddf_pkg::RS_NNB]) |-> o_rx_wbk_word[eddf_pkg::RS_ES])
		else $error("error summary missing");
	a_trunc_mark: assert property (@(posedge i_clk) disable iff (!i_rstn)
		state_ff == eddf_pkg::RX_FILL && !i_rx_eof && i_rx_byte && own && buf_full
			&& !nx_own |=> o_rx_wbk_vld && o_rx_wbk_word[eddf_pkg::RS_NNB]
			&& state_ff == eddf_pkg::RX_DROP)
		else $error("truncation not reported");
	a_len_extra: assert property (@(posedge i_clk) disable iff (!i_rstn)
		state_ff == eddf_pkg::RX_FILL && i_rx_eof && add_two |=> o_rx_wbk_word[
			eddf_pkg::RS_FL_MSB:eddf_pkg::RS_FL_LSB] == $past(len_ff) + eddf_pkg::CSUM_EXTRA)
		else $error("checksum bytes not counted");
	a_frame_len: assert property (@(posedge i_clk) disable iff (!i_rstn)
		state_ff == eddf_pkg::RX_FILL && i_rx_eof && !add_two |=> o_rx_wbk_word[
			eddf_pkg::RS_FL_MSB:eddf_pkg::RS_FL_LSB] == $past(len_ff))
		else $error("frame length wrong");
	a_next_fetch: assert property (@(posedge i_clk) disable iff (!i_rstn)
		tx_end && !tx_last |=> o_fetch_desc && o_fetch_addr == $past(tx_next_ff))
		else $error("chained descriptor not fetched");
	a_own_fresh: assert property (@(posedge i_clk) disable iff (!i_rstn)
		state_ff == eddf_pkg::RX_FILL && !i_rx_eof && i_rx_byte && own && buf_full
			&& nx_own |=> o_rx_own && o_rx_wbk_vld && !o_rx_wbk_word[eddf_pkg::RS_LAST])
		else $error("next descriptor not taken over");
	a_dest_fail: assert property (@(posedge i_clk) disable iff (!i_rstn)
		state_ff == eddf_pkg::RX_FILL && i_rx_eof
			|=> o_rx_wbk_word[eddf_pkg::RS_DAF] == $past(i_rx_info.da_fail))
		else $error("destination filter flag wrong");
	a_src_fail: assert property (@(posedge i_clk) disable iff (!i_rstn)
		state_ff == eddf_pkg::RX_FILL && i_rx_eof
			|=> o_rx_wbk_word[eddf_pkg::RS_SAF] == $past(i_rx_info.sa_fail))
		else $error("source filter flag wrong");
	a_ovf_flag: assert property (@(posedge i_clk) disable iff (!i_rstn)
		state_ff == eddf_pkg::RX_FILL && i_rx_eof
			|=> o_rx_wbk_word[eddf_pkg::RS_OVF] == $past(i_rx_info.overflow))
		else $error("overflow flag wrong");
	a_vlan_flag: assert property (@(posedge i_clk) disable iff (!i_rstn)
		state_ff == eddf_pkg::RX_FILL && i_rx_eof
			|=> o_rx_wbk_word[eddf_pkg::RS_VLAN] == $past(i_rx_info.vlan))
		else $error("vlan flag wrong");
	a_size_gate: assert property (@(posedge i_clk) disable iff (!i_rstn)
		state_ff == eddf_pkg::RX_FILL && i_rx_eof && i_rx_info.eth_type
			|=> !o_rx_wbk_word[eddf_pkg::RS_LEN])
		else $error("size mismatch shown for typed frame");
	a_last_mark: assert property (@(posedge i_clk) disable iff (!i_rstn)
		state_ff == eddf_pkg::RX_FILL && i_rx_eof
			|=> o_rx_wbk_vld && o_rx_wbk_word[eddf_pkg::RS_LAST])
		else $error("last buffer mark missing");
	a_first_mark: assert property (@(posedge i_clk) disable iff (!i_rstn)
		state_ff == eddf_pkg::RX_FILL && !i_rx_eof && i_rx_byte && own && !buf_full
			&& !sw_rs && (first_ff || rx_stat_ff[eddf_pkg::RS_FIRST])
			|=> rx_stat_ff[eddf_pkg::RS_FIRST])
		else $error("first buffer mark lost");
endmodule
